// ==== inc/dma_pkg.sv ====
// Summary of operation
// - Fixed priority, channel 0 highest, 3 lowest
// - Pick best requester other than current channel
// - New channel starts after bus released
// - Other master's cycle runs before handover
// - No channel switch inside burst or block
// - Read source then write destination, bus held
// - Bus controller sets wait states and widths
// - Cycle stealing releases bus after each unit
// - Released gaps let other masters run cycles
// - Burst runs units back to back until end
// - Burst holds off higher-priority channels
// - Block mode moves one block per request
// - Pin sampled every cycle after enable write
// - Sampled low level latches pending request
// - Edge mode clears request, then needs high
// - High seen before write end rearms after it
// - Level mode rearms after write completes
// - Accept, transfer, rearm repeats until done
// - Enable bit set by software, cleared on end
// - Active flag low when idle or releasing bus, high while waiting for grant
package dma_pkg;

  localparam int NCH  = 4;
  localparam int CHW  = 2;
  localparam int BLKW = 8;
  localparam int CNTW = 16;

  // APB byte offsets
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CNT0  = 8'h10;
  localparam logic [7:0] OFF_STAT  = 8'h20;
  localparam logic [7:0] CH_STRIDE = 8'h04;

  // Fields of channel_mode_control_register
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_ACT_BIT  = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_PIN_BIT  = 4;
  localparam int CTRL_EDGE_BIT = 5;
  localparam int CTRL_BLK_LSB  = 8;

  // Fields of status register
  localparam int STAT_ACT_LSB = 0;
  localparam int STAT_CUR_LSB = 4;
  localparam int STAT_BUS_BIT = 8;

  localparam logic [BLKW-1:0] BLK_RST = 8'h01;
  localparam logic [CNTW-1:0] CNT_RST = 16'h0000;

  typedef enum logic [1:0] {
    XM_STEAL = 2'h0,
    XM_BURST = 2'h1,
    XM_BLOCK = 2'h2
  } xfer_mode_t;

  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_GNT   = 5'h02,
    S_READ  = 5'h04,
    S_WRITE = 5'h08,
    S_REL   = 5'h10
  } dma_state_t;

endpackage : dma_pkg

// ==== hw/req_catch.sv ====
`timescale 1ns/1ps
module req_catch
  import dma_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin
  input  wire logic ext_req_pin_n,
  // Control
  input  wire logic sample_en,
  input  wire logic edge_mode,
  input  wire logic activate,
  input  wire logic write_done,
  // Result
  output logic      pending
);

  logic sync1_r;
  logic sync2_r;
  logic pend_r;
  logic accept_r;
  logic hi_seen_r;
  logic done_seen_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end else begin
      sync1_r <= ext_req_pin_n;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r      <= 1'b0;
      accept_r    <= 1'b1;
      hi_seen_r   <= 1'b0;
      done_seen_r <= 1'b0;
    end else if (!sample_en) begin
      pend_r      <= 1'b0;
      accept_r    <= 1'b1;
      hi_seen_r   <= 1'b0;
      done_seen_r <= 1'b0;
    end else if (activate) begin
      pend_r      <= 1'b0;
      accept_r    <= 1'b0;
      hi_seen_r   <= 1'b0;
      done_seen_r <= 1'b0;
    end else if (accept_r) begin
      if (!sync2_r) begin
        pend_r <= 1'b1;
      end
    end else begin
      if (sync2_r) begin
        hi_seen_r <= 1'b1;
      end
      if (write_done) begin
        done_seen_r <= 1'b1;
      end
      // Edge mode also needs the pin back high first
      if ((write_done || done_seen_r) && (!edge_mode || sync2_r || hi_seen_r)) begin
        accept_r <= 1'b1;
      end
    end
  end

  assign pending = pend_r;

endmodule : req_catch

// ==== hw/prio_arbiter.sv ====
`timescale 1ns/1ps
module prio_arbiter
  import dma_pkg::*;
(
  // Requests
  input  wire logic [NCH-1:0] req,
  input  wire logic           excl_vld,
  input  wire logic [CHW-1:0] excl_ch,
  // Choice
  output logic                pick_vld,
  output logic [CHW-1:0]      pick_ch
);

  function automatic logic [CHW-1:0] lowest_set(input logic [NCH-1:0] v);
    lowest_set = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest_set = CHW'(i);
      end
    end
  endfunction : lowest_set

  logic [NCH-1:0] others;

  always_comb begin
    others = req;
    if (excl_vld) begin
      others[excl_ch] = 1'b0;
    end
  end

  // Lowest index wins; the current channel only when alone
  assign pick_vld = |req;
  assign pick_ch  = (|others) ? lowest_set(others) : lowest_set(req);

endmodule : prio_arbiter

// ==== hw/dma_channel_arbitration_request.sv ====
`timescale 1ns/1ps
module dma_channel_arbitration_request
  import dma_pkg::*;
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  // External request pins
  input  wire logic [NCH-1:0]   ext_req_pin_n,
  // Bus controller
  output logic                  bus_req,
  input  wire logic             bus_gnt,
  input  wire logic             other_req,
  output logic                  cyc_req,
  output logic                  cyc_write,
  output logic [CHW-1:0]        cyc_ch,
  output logic [31:0]           cyc_wdata,
  input  wire logic             cyc_ack,
  input  wire logic [31:0]      cyc_rdata
);

  dma_state_t         state_r;
  dma_state_t         state_nxt;
  logic [NCH-1:0]     en_r;
  xfer_mode_t         mode_r   [NCH];
  logic [NCH-1:0]     pin_en_r;
  logic [NCH-1:0]     edge_r;
  logic [BLKW-1:0]    blk_r    [NCH];
  logic [CNTW-1:0]    cnt_r    [NCH];
  logic [CHW-1:0]     cur_ch_r;
  logic               have_last_r;
  logic [BLKW-1:0]    blk_left_r;
  logic [31:0]        rd_buf_r;
  logic [NCH-1:0]     pin_pend;
  logic [NCH-1:0]     pend;
  logic [NCH-1:0]     act_pulse;
  logic [NCH-1:0]     wr_pulse;
  logic [NCH-1:0]     act_flag;
  logic               arb_vld;
  logic [CHW-1:0]     arb_ch;
  logic               wr_ack;
  logic               cnt_last;
  logic               unit_last;
  logic               apb_wr;
  logic               apb_rd;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !pwrite;
  assign wr_ack = (state_r == S_WRITE) && cyc_ack;
  assign cnt_last = (cnt_r[cur_ch_r] == 16'h0001);

  function automatic logic is_ctrl(input logic [7:0] a);
    is_ctrl = (a >= OFF_CTRL0) && (a < OFF_CNT0) && (a[1:0] == 2'h0);
  endfunction : is_ctrl

  function automatic logic is_cnt(input logic [7:0] a);
    is_cnt = (a >= OFF_CNT0) && (a < OFF_STAT) && (a[1:0] == 2'h0);
  endfunction : is_cnt

  function automatic logic [CHW-1:0] ch_of(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = (a - base) / CH_STRIDE;
    ch_of = d[CHW-1:0];
  endfunction : ch_of

  // Request detection, one per channel
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_req
      req_catch u_req (
        .pclk          (pclk),
        .presetn       (presetn),
        .ext_req_pin_n (ext_req_pin_n[g]),
        .sample_en     (en_r[g] && pin_en_r[g]),
        .edge_mode     (edge_r[g]),
        .activate      (act_pulse[g]),
        .write_done    (wr_pulse[g]),
        .pending       (pin_pend[g])
      );
      // Without pin requests the channel asks on its own
      assign pend[g]      = en_r[g] && (pin_en_r[g] ? pin_pend[g] : 1'b1);
      assign act_pulse[g] = (state_r == S_IDLE) && arb_vld && (arb_ch == CHW'(g));
      assign wr_pulse[g]  = wr_ack && (cur_ch_r == CHW'(g));
      assign act_flag[g]  = (state_r inside {S_GNT, S_READ, S_WRITE})
                            && (cur_ch_r == CHW'(g));
    end
  endgenerate

  prio_arbiter u_arb (
    .req      (pend),
    .excl_vld (have_last_r),
    .excl_ch  (cur_ch_r),
    .pick_vld (arb_vld),
    .pick_ch  (arb_ch)
  );

  // Whether the current unit ends this channel's tenure
  always_comb begin
    unique case (mode_r[cur_ch_r])
      XM_BURST: unit_last = cnt_last || !en_r[cur_ch_r];
      XM_BLOCK: unit_last = cnt_last || (blk_left_r <= 8'h01);
      default:  unit_last = 1'b1;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE:  if (arb_vld) state_nxt = S_GNT;
      S_GNT:   if (bus_gnt) state_nxt = S_READ;
      S_READ:  if (cyc_ack) state_nxt = S_WRITE;
      S_WRITE: if (cyc_ack) state_nxt = unit_last ? S_REL : S_READ;
      S_REL:   if (!other_req) state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Bus held from grant request through the last write
  assign bus_req   = state_r inside {S_GNT, S_READ, S_WRITE};
  assign cyc_req   = state_r inside {S_READ, S_WRITE};
  assign cyc_write = (state_r == S_WRITE);
  assign cyc_ch    = cur_ch_r;
  assign cyc_wdata = rd_buf_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ch_r    <= '0;
      have_last_r <= 1'b0;
    end else if (state_r == S_IDLE && arb_vld) begin
      cur_ch_r    <= arb_ch;
      have_last_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_left_r <= BLK_RST;
    end else if (state_r == S_IDLE && arb_vld) begin
      blk_left_r <= blk_r[arb_ch];
    end else if (wr_ack && blk_left_r != 8'h00) begin
      blk_left_r <= blk_left_r - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_buf_r <= 32'h0000_0000;
    end else if (state_r == S_READ && cyc_ack) begin
      rd_buf_r <= cyc_rdata;
    end
  end

  // Channel configuration; a write of the enable bit beats the auto clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r     <= '0;
      pin_en_r <= '0;
      edge_r   <= '0;
      for (int i = 0; i < NCH; i++) begin
        mode_r[i] <= XM_STEAL;
        blk_r[i]  <= BLK_RST;
      end
    end else begin
      if (wr_ack && cnt_last) begin
        en_r[cur_ch_r] <= 1'b0;
      end
      if (apb_wr && is_ctrl(paddr)) begin
        en_r[ch_of(paddr, OFF_CTRL0)]     <= pwdata[CTRL_EN_BIT];
        pin_en_r[ch_of(paddr, OFF_CTRL0)] <= pwdata[CTRL_PIN_BIT];
        edge_r[ch_of(paddr, OFF_CTRL0)]   <= pwdata[CTRL_EDGE_BIT];
        mode_r[ch_of(paddr, OFF_CTRL0)]   <=
          xfer_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
        blk_r[ch_of(paddr, OFF_CTRL0)]    <= pwdata[CTRL_BLK_LSB +: BLKW];
      end
    end
  end

  // Zero count means no limit, so it never ends the channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        cnt_r[i] <= CNT_RST;
      end
    end else begin
      if (wr_ack && cnt_r[cur_ch_r] != CNT_RST) begin
        cnt_r[cur_ch_r] <= cnt_r[cur_ch_r] - 16'h0001;
      end
      if (apb_wr && is_cnt(paddr)) begin
        cnt_r[ch_of(paddr, OFF_CNT0)] <= pwdata[CNTW-1:0];
      end
    end
  end

  // APB answers in the first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable
                   && !(is_ctrl(paddr) || is_cnt(paddr) || paddr == OFF_STAT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd && !penable) begin
      prdata <= 32'h0000_0000;
      if (is_ctrl(paddr)) begin
        prdata[CTRL_EN_BIT]           <= en_r[ch_of(paddr, OFF_CTRL0)];
        prdata[CTRL_ACT_BIT]          <= act_flag[ch_of(paddr, OFF_CTRL0)];
        prdata[CTRL_MODE_LSB +: 2]    <= mode_r[ch_of(paddr, OFF_CTRL0)];
        prdata[CTRL_PIN_BIT]          <= pin_en_r[ch_of(paddr, OFF_CTRL0)];
        prdata[CTRL_EDGE_BIT]         <= edge_r[ch_of(paddr, OFF_CTRL0)];
        prdata[CTRL_BLK_LSB +: BLKW]  <= blk_r[ch_of(paddr, OFF_CTRL0)];
      end else if (is_cnt(paddr)) begin
        prdata[CNTW-1:0] <= cnt_r[ch_of(paddr, OFF_CNT0)];
      end else if (paddr == OFF_STAT) begin
        prdata[STAT_ACT_LSB +: NCH] <= act_flag;
        prdata[STAT_CUR_LSB +: CHW] <= cur_ch_r;
        prdata[STAT_BUS_BIT]        <= bus_req;
      end
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence read_done_s;
    (state_r == S_READ) && cyc_ack;
  endsequence

  sequence write_phase_s;
    (state_r == S_WRITE) && bus_req && cyc_write;
  endsequence

  a_prio_ch0_first: assert property (
    (state_r == S_IDLE) && pend[0] && !(have_last_r && cur_ch_r == 2'h0)
    |=> (state_r == S_GNT) && (cur_ch_r == 2'h0))
    else $error("channel 0 not chosen first");

  a_pick_other_ch: assert property (
    (state_r == S_IDLE) && have_last_r && (pend[0] || pend[1] || pend[2] || pend[3])
    && (pend != (4'h1 << cur_ch_r))
    |=> cur_ch_r != $past(cur_ch_r))
    else $error("current channel chosen over others");

  a_start_after_gnt: assert property (
    $rose(state_r == S_READ) && $past(state_r == S_GNT) |-> $past(bus_gnt))
    else $error("read began without bus grant");

  a_yield_other: assert property (
    (state_r == S_REL) && other_req |=> !bus_req)
    else $error("bus not yielded to other master");

  a_burst_keeps_ch: assert property (
    wr_ack && (mode_r[cur_ch_r] == XM_BURST) && !unit_last
    |=> (state_r == S_READ) && $stable(cur_ch_r))
    else $error("burst switched channel");

  a_read_then_write: assert property (
    read_done_s |=> write_phase_s)
    else $error("write did not follow read on held bus");

  a_cycle_held: assert property (
    cyc_req && !cyc_ack |=> cyc_req && $stable(cyc_write) && $stable(cyc_ch))
    else $error("bus cycle dropped before ack");

  a_steal_release: assert property (
    wr_ack && (mode_r[cur_ch_r] == XM_STEAL) |=> !bus_req ##1 !cyc_req)
    else $error("cycle steal kept bus after unit");

  a_block_length: assert property (
    wr_ack && (mode_r[cur_ch_r] == XM_BLOCK) && (blk_left_r > 8'h01) && !cnt_last
    |=> state_r == S_READ)
    else $error("block ended early");

  a_act_clears: assert property (
    (state_r == S_IDLE) && arb_vld && pin_en_r[arb_ch] |=> !pin_pend[cur_ch_r])
    else $error("request not cleared on activation");

  a_enable_clear: assert property (
    wr_ack && cnt_last && !apb_wr |=> !en_r[$past(cur_ch_r)])
    else $error("enable not cleared at count end");

  a_idle_inactive: assert property (
    (state_r == S_IDLE) || (state_r == S_REL) |-> act_flag == 4'h0)
    else $error("active flag set while idle");

  sequence tenure_end_s;
    wr_ack && unit_last;
  endsequence

  a_gap_after_unit: assert property (
    tenure_end_s |=> !bus_req && (state_r == S_REL))
    else $error("bus not released after tenure");

  a_burst_runs_on: assert property (
    wr_ack && (mode_r[cur_ch_r] == XM_BURST) && !cnt_last && en_r[cur_ch_r]
    |=> (state_r == S_READ) && bus_req)
    else $error("burst released before its end");

  a_burst_holds_bus: assert property (
    (state_r inside {S_READ, S_WRITE}) && (mode_r[cur_ch_r] == XM_BURST)
    && !(wr_ack && unit_last) |=> bus_req && $stable(cur_ch_r))
    else $error("burst gave up the bus");

  a_block_release: assert property (
    wr_ack && (mode_r[cur_ch_r] == XM_BLOCK) && (blk_left_r <= 8'h01)
    |=> !bus_req)
    else $error("bus kept after block end");

  a_wait_grant: assert property (
    (state_r == S_GNT) && !bus_gnt |=> (state_r == S_GNT) && !cyc_req)
    else $error("cycle started without grant");

  a_busy_active: assert property (
    (state_r inside {S_GNT, S_READ, S_WRITE}) |-> act_flag[cur_ch_r])
    else $error("active flag low during tenure");

  a_rearbitrate: assert property (
    (state_r == S_REL) && !other_req |=> state_r == S_IDLE)
    else $error("arbitration skipped after release");

  // Per-channel pin checks
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_pin_chk
      a_pin_gated: assert property (@(posedge pclk) disable iff (!presetn)
        !(en_r[g] && pin_en_r[g]) |=> !pin_pend[g])
        else $error("pin request kept while sampling is off");
      a_req_held: assert property (@(posedge pclk) disable iff (!presetn)
        pin_pend[g] && en_r[g] && pin_en_r[g] && !act_pulse[g] |=> pin_pend[g])
        else $error("held pin request lost");
    end
  endgenerate

endmodule : dma_channel_arbitration_request

// ==== tb/bus_partner.sv ====
`timescale 1ns/1ps
module bus_partner (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Channel side
  input  wire logic        bus_req,
  output logic             bus_gnt,
  input  wire logic        cyc_req,
  output logic             cyc_ack,
  output logic [31:0]      cyc_rdata,
  // Wait states per bus cycle
  input  wire logic [3:0]  ack_wait
);
  logic [3:0]  wait_r;
  logic [31:0] seq_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_gnt <= 1'b0;
    end else begin
      bus_gnt <= bus_req;
    end
  end

  // Wait states live here, not in the channel logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_ack <= 1'b0;
      wait_r  <= 4'h0;
    end else if (cyc_req && !cyc_ack && wait_r >= ack_wait) begin
      cyc_ack <= 1'b1;
      wait_r  <= 4'h0;
    end else begin
      cyc_ack <= 1'b0;
      wait_r  <= (cyc_req && !cyc_ack) ? wait_r + 4'h1 : 4'h0;
    end
  end

  // Data moves every cycle so a late sample shows up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_r <= 32'h5a5a_0000;
    end else begin
      seq_r <= seq_r + 32'h0000_0001;
    end
  end

  assign cyc_rdata = cyc_ack ? seq_r : ~seq_r;
endmodule : bus_partner

// ==== tb/dma_channel_arbitration_request_bench.sv ====
`timescale 1ns/1ps
module dma_channel_arbitration_request_bench
  import dma_pkg::*;
;
  logic             pclk          = 1'b0;
  logic             presetn       = 1'b0;
  logic             psel          = 1'b0;
  logic             penable       = 1'b0;
  logic             pwrite        = 1'b0;
  logic [7:0]       paddr         = 8'h00;
  logic [31:0]      pwdata        = 32'h0;
  logic [NCH-1:0]   ext_req_pin_n = 4'hf;
  logic             other_req     = 1'b0;
  logic [3:0]       ack_wait      = 4'h0;
  logic [31:0]      prdata, cyc_wdata, cyc_rdata, rdata, rd_word;
  logic             pready, pslverr, bus_req, bus_gnt, cyc_req, cyc_write, cyc_ack;
  logic             rerr, rd_seen;
  logic [CHW-1:0]   cyc_ch;
  logic [CHW-1:0]   got_q[$];
  int               fail_count    = 0;
  int               cmp_count     = 0;
  int               cycles        = 0;

  dma_channel_arbitration_request dma_channel_arbitration_request_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_req_pin_n(ext_req_pin_n), .bus_req(bus_req), .bus_gnt(bus_gnt),
    .other_req(other_req), .cyc_req(cyc_req), .cyc_write(cyc_write), .cyc_ch(cyc_ch),
    .cyc_wdata(cyc_wdata), .cyc_ack(cyc_ack), .cyc_rdata(cyc_rdata));

  bus_partner bus_partner_i (
    .pclk(pclk), .presetn(presetn), .bus_req(bus_req), .bus_gnt(bus_gnt),
    .cyc_req(cyc_req), .cyc_ack(cyc_ack), .cyc_rdata(cyc_rdata), .ack_wait(ack_wait));

  always #4 pclk = ~pclk;

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Entered right after a rising edge; leaves one idle edge behind
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  function automatic logic [31:0] cv(input logic en, input logic [1:0] m, input logic pe,
                                     input logic ed, input logic [7:0] bk);
    return {16'h0000, bk, 2'b00, ed, pe, m, 1'b0, en};
  endfunction : cv

  task automatic arm(input int ch, input logic [31:0] ctl, input logic [15:0] cnt);
    apb(1'b1, 8'(OFF_CNT0 + CH_STRIDE * ch), {16'h0000, cnt});
    apb(1'b1, 8'(OFF_CTRL0 + CH_STRIDE * ch), ctl);
  endtask : arm

  // n > 0: that many units done; n == 0: cycle (or write cycle if w) under way
  task automatic wait_for(input int n, input logic w);
    while ((n > 0) ? (got_q.size() < n) : ((w ? cyc_write : cyc_req) !== 1'b1)) begin
      @(negedge pclk);
    end
    @(posedge pclk);
  endtask : wait_for

  task automatic chk_seq(input int n, input logic [31:0] s);
    for (int i = 0; i < n; i++) begin
      check(32'(got_q[i]), 32'(s[4*(n-1-i) +: 4]));
    end
    got_q.delete();
  endtask : chk_seq

  // Log each unit at its write acknowledge
  always @(posedge pclk) begin
    if (presetn && cyc_req === 1'b1 && cyc_ack === 1'b1) begin
      if (cyc_write === 1'b0) begin
        rd_word = cyc_rdata;
        rd_seen = 1'b1;
      end else begin
        check({31'h0, rd_seen}, 32'h1);
        check(cyc_wdata, rd_word);
        rd_seen = 1'b0;
        got_q.push_back(cyc_ch);
      end
    end
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    rd_seen = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_CTRL0, 32'h0);
    check(rdata, cv(1'b0, XM_STEAL, 1'b0, 1'b0, BLK_RST));
    apb(1'b0, OFF_STAT, 32'h0);
    check(rdata, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    check({31'h0, rerr}, 32'h1);
    // All four pins fall together
    for (int c = 3; c >= 0; c--) begin
      arm(c, cv(1'b1, XM_STEAL, 1'b1, 1'b0, 8'h01), 16'h0001);
    end
    ext_req_pin_n <= 4'h0;
    wait_for(4, 1'b0);
    chk_seq(4, 32'h0123);
    ext_req_pin_n <= 4'hf;
    // Two level requesters alternate; other master takes the gap
    ack_wait <= 4'h3;
    arm(1, cv(1'b1, XM_STEAL, 1'b1, 1'b0, 8'h01), 16'h0002);
    arm(0, cv(1'b1, XM_STEAL, 1'b1, 1'b0, 8'h01), 16'h0002);
    ext_req_pin_n <= 4'hc;
    wait_for(0, 1'b1);
    other_req <= 1'b1;
    wait_for(1, 1'b0);
    repeat (5) begin
      @(negedge pclk);
      check({31'h0, bus_req}, 32'h0);
    end
    @(posedge pclk);
    other_req <= 1'b0;
    wait_for(4, 1'b0);
    chk_seq(4, 32'h0101);
    ext_req_pin_n <= 4'hf;
    // Burst on channel 1 holds off channel 0
    arm(1, cv(1'b1, XM_BURST, 1'b1, 1'b0, 8'h01), 16'h0003);
    ext_req_pin_n <= 4'hd;
    wait_for(0, 1'b0);
    arm(0, cv(1'b1, XM_STEAL, 1'b0, 1'b0, 8'h01), 16'h0001);
    apb(1'b0, OFF_STAT, 32'h0);
    check(rdata & 32'h0000_0132, 32'h0000_0112);
    wait_for(4, 1'b0);
    chk_seq(4, 32'h1110);
    ext_req_pin_n <= 4'hf;
    // Two-unit blocks on channel 2, channel 0 between them
    arm(2, cv(1'b1, XM_BLOCK, 1'b1, 1'b0, 8'h02), 16'h0004);
    ext_req_pin_n <= 4'hb;
    wait_for(0, 1'b0);
    arm(0, cv(1'b1, XM_STEAL, 1'b0, 1'b0, 8'h01), 16'h0001);
    wait_for(5, 1'b0);
    chk_seq(5, 32'h22022);
    // Falling-edge mode needs a high level between requests
    ext_req_pin_n <= 4'h7;
    arm(3, cv(1'b1, XM_STEAL, 1'b1, 1'b1, 8'h01), 16'h0003);
    wait_for(1, 1'b0);
    repeat (20) @(posedge pclk);
    check(32'(got_q.size()), 32'h1);
    ext_req_pin_n <= 4'hf;
    repeat (3) @(posedge pclk);
    ext_req_pin_n <= 4'h7;
    // Pin back high while the write is still running
    wait_for(0, 1'b1);
    ext_req_pin_n <= 4'hf;
    repeat (6) @(posedge pclk);
    ext_req_pin_n <= 4'h7;
    wait_for(3, 1'b0);
    chk_seq(3, 32'h333);
    repeat (2) @(posedge pclk);
    apb(1'b0, 8'(OFF_CTRL0 + CH_STRIDE * 3), 32'h0);
    check(rdata, cv(1'b0, XM_STEAL, 1'b1, 1'b1, 8'h01));
    final_report();
  end
endmodule : dma_channel_arbitration_request_bench
